// [test/pmx_board_model.sv]
/*
 Board model: pulls on reset lines, strap and flash loader.
 Assumes the device drives the glitch pins and flash function.
*/
module pmx_board_model #(
    parameter logic [3:0] LOAD_CYC = 4'h4
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Device pins
    input wire logic sys_i,
    input wire logic sys_oe_i,
    input wire logic res_i,
    input wire logic res_oe_i,
    input wire logic aon_i,
    input wire logic aon_oe_i,
    input wire logic [1:0] flash_func_i,
    // Board setup
    input wire logic sel_cfg_i,
    input wire logic ok_cfg_i,
    // Board lines
    output logic sys_line_o,
    output logic res_line_o,
    output logic aon_line_o,
    output logic select_o,
    output logic done_o,
    output logic ok_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt = 4'h0;
    // Pull-downs on reset outputs, pull-up on always-on reset
    assign sys_line_o = sys_oe_i ? sys_i : 1'b0;
    assign res_line_o = res_oe_i ? res_i : 1'b0;
    assign aon_line_o = (aon_oe_i && !aon_i) ? 1'b0 : 1'b1;
    // Strap, pulled down when no private flash
    assign select_o = sel_cfg_i;
    // Load result only valid with done
    assign done_o = (wait_cnt == LOAD_CYC);
    assign ok_o = done_o ? ok_cfg_i : !ok_cfg_i;
    always @(posedge mclk_i) begin
        if (sys_rst_i || flash_func_i != 2'h1) wait_cnt <= 4'h0;
        else if (!done_o) wait_cnt <= wait_cnt + 4'h1;
    end
endmodule // pmx_board_model

// [test/pmx_pin_ctrl_monitor.sv]
/*
 Checker for the pin power-up and mux override block.
 Assumes one clock and a synchronous active-high reset.
*/
module pmx_pin_ctrl_monitor #(
    parameter SCAN_PINS = 8
) (
    // Clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // Inputs
    input wire always_on_rail_good_i,
    input wire main_power_good_i,
    input wire debug_rst_pin_i,
    input wire dbg_tdo_oe_i,
    input wire host_rst_gpio_sel_i,
    input wire sysrst_drive_bit_i,
    input wire resume_gpio_data_i,
    input wire always_on_rst_req_i,
    // Outputs
    input wire host_bus_reset_n_o,
    input wire system_rst_drive_pin_o,
    input wire system_rst_drive_pin_oe_o,
    input wire resume_rst_pin_o,
    input wire resume_rst_pin_oe_o,
    input wire always_on_rst_pin_o,
    input wire always_on_rst_pin_oe_o,
    input wire third_twowire_data_pin_o,
    input wire third_twowire_data_pin_oe_o,
    input wire dbg_routed_o,
    input wire dbg_tdo_pin_oe_o,
    input wire [1:0] shared_flash_func_o,
    input wire [SCAN_PINS-1:0] matrix_scan_input_pu_o,
    input wire boot_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] good_cnt;
    wire stable = (good_cnt >= 4'hD);
    // Cycles the rail has been good, saturating
    always @(posedge mclk_i) begin
        if (sys_rst_i || !always_on_rail_good_i) good_cnt <= 4'h0;
        else if (good_cnt != 4'hF) good_cnt <= good_cnt + 4'h1;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    host_gate_a: assert property (host_rst_gpio_sel_i |=> !host_bus_reset_n_o)
        else $error("host reset not gated");
    dbg_route_a: assert property (debug_rst_pin_i |=> dbg_routed_o && dbg_tdo_pin_oe_o == $past(dbg_tdo_oe_i))
        else $error("debug port not routed");
    dbg_release_a: assert property (!debug_rst_pin_i |=> !dbg_routed_o)
        else $error("debug port routed while low");
    sysrst_hold_a: assert property ((!main_power_good_i || sysrst_drive_bit_i) |=> !system_rst_drive_pin_o)
        else $error("system reset released early");
    resume_hold_a: assert property (!resume_gpio_data_i |=> !resume_rst_pin_o)
        else $error("resume reset released early");
    glitch_low_a: assert property ($rose(always_on_rail_good_i) |=> (!system_rst_drive_pin_o
        && system_rst_drive_pin_oe_o && !resume_rst_pin_o && resume_rst_pin_oe_o && !always_on_rst_pin_o
        && always_on_rst_pin_oe_o && !third_twowire_data_pin_o && third_twowire_data_pin_oe_o)[*8])
        else $error("glitch pins not held low");
    aon_od_a: assert property (stable |=> always_on_rst_pin_oe_o == $past(always_on_rst_req_i) && !always_on_rst_pin_o)
        else $error("always-on reset not open drain");
    push_pull_a: assert property (stable |=> system_rst_drive_pin_oe_o && resume_rst_pin_oe_o)
        else $error("reset pins not push-pull");
    twowire_in_a: assert property (stable |=> !third_twowire_data_pin_oe_o)
        else $error("two-wire data pin driven");
    boot_shared_a: assert property (boot_done_o |-> shared_flash_func_o == 2'h1)
        else $error("shared flash pins not set");
    scan_pullup_a: assert property (boot_done_o |-> matrix_scan_input_pu_o == {SCAN_PINS{1'b1}})
        else $error("scan pull-ups missing");
endmodule // pmx_pin_ctrl_monitor
bind pmx_pin_ctrl pmx_pin_ctrl_monitor #(.SCAN_PINS(SCAN_PINS)) u_pmx_pin_ctrl_monitor (.*);

// [test/pmx_pin_ctrl_test.sv]
/*
 Testbench for the pin power-up and mux override block.
 Assumes the board model and the bound checker.
*/
module pmx_pin_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, sys_rst_i = 1, always_on_rail_good_i = 0, main_power_good_i = 0, debug_rst_pin_i = 0;
    logic dbg_tdo_i = 0, dbg_tdo_oe_i = 0, host_bus_reset_n_i = 1, host_rst_gpio_sel_i = 0, sysrst_drive_bit_i = 1;
    logic resume_gpio_data_i = 0, always_on_rst_req_i = 0, sel_cfg = 0, ok_cfg = 0;
    logic private_flash_select_i, flash_load_ok_i, flash_load_done_i, sys_line, resume_line, aon_line;
    logic [7:0] pin_ctl_we_i = 0, pin_alt_out_i = 0, pin_alt_oe_i = 0, pin_data_i = 0;
    logic [39:0] pin_ctl_wdata_i = 0, pin_ctl_o, shadow = 0;
    logic [7:0] pin_out_o, pin_oe_o, matrix_scan_input_pu_o;
    logic host_bus_reset_n_o, system_rst_drive_pin_o, system_rst_drive_pin_oe_o, resume_rst_pin_o;
    logic resume_rst_pin_oe_o, always_on_rst_pin_o, always_on_rst_pin_oe_o, third_twowire_data_pin_o;
    logic third_twowire_data_pin_oe_o, dbg_routed_o, dbg_tdo_pin_o, dbg_tdo_pin_oe_o, boot_done_o;
    logic [1:0] shared_flash_func_o, private_flash_func_o;
    logic [63:0] r;
    logic [1:0] e;
    int n_mismatch, checked, k;
    pmx_pin_ctrl #(.NUM_PINS(8), .SCAN_PINS(8)) u_pmx_pin_ctrl (.*);
    pmx_board_model u_pmx_board_model (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sys_i(system_rst_drive_pin_o),
        .sys_oe_i(system_rst_drive_pin_oe_o), .res_i(resume_rst_pin_o), .res_oe_i(resume_rst_pin_oe_o),
        .aon_i(always_on_rst_pin_o), .aon_oe_i(always_on_rst_pin_oe_o), .flash_func_i(shared_flash_func_o),
        .sel_cfg_i(sel_cfg), .ok_cfg_i(ok_cfg), .sys_line_o(sys_line), .res_line_o(resume_line),
        .aon_line_o(aon_line), .select_o(private_flash_select_i), .done_o(flash_load_done_i), .ok_o(flash_load_ok_i));
    initial forever #10 mclk_i = ~mclk_i;
    function automatic logic [1:0] exp_priv(input logic sel, input logic ok);
        return (sel && ok) ? 2'h1 : 2'h0;
    endfunction
    function automatic logic [39:0] merge(input logic [39:0] old, input logic [7:0] we, input logic [39:0] wd);
        for (int j = 0; j < 8; j++) if (we[j]) old[5*j +: 5] = wd[5*j +: 5];
        return old;
    endfunction
    function automatic logic [1:0] exp_pin(input logic [4:0] w, input logic ao, input logic aoe, input logic d);
        if (w[1:0] != 2'h0) return {ao, aoe};
        if (w[2]) return {d, w[3] ? !d : 1'b1};
        return 2'b00;
    endfunction
    task chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task power_up(input logic sel, input logic ok);
        int i;
        sys_rst_i <= 1'b1;
        always_on_rail_good_i <= 1'b0;
        main_power_good_i <= 1'b0;
        sysrst_drive_bit_i <= 1'b1;
        resume_gpio_data_i <= 1'b0;
        sel_cfg <= sel;
        ok_cfg <= ok;
        step(3);
        sys_rst_i <= 1'b0;
        step(1);
        always_on_rail_good_i <= 1'b1;
        #1;
        chk("reset_pins", {sys_line, resume_line, aon_line}, 3'b000);
        chk("pin_oe", pin_oe_o, 8'h00);
        chk("pin_ctl", pin_ctl_o, 40'h0);
        for (i = 0; i < 60 && boot_done_o !== 1'b1; i++) step(1);
        #1;
        chk("boot_done", boot_done_o, 1'b1);
        chk("aon_oe", {always_on_rst_pin_oe_o, aon_line}, 2'b01);
        chk("pp_oe", {system_rst_drive_pin_oe_o, resume_rst_pin_oe_o}, 2'b11);
        chk("tw_oe", third_twowire_data_pin_oe_o, 1'b0);
        chk("shared", shared_flash_func_o, 2'h1);
        chk("scan_pu", matrix_scan_input_pu_o, 8'hFF);
        chk("private", private_flash_func_o, exp_priv(sel, ok));
        chk("resume", resume_line, 1'b0);
    endtask
    initial begin
        repeat (3000) @(posedge mclk_i);
        n_mismatch++;
        end_sim;
    end
    initial begin
        void'($urandom(86089));
        for (k = 0; k < 3; k++) begin
            if (k > 0) step(1);
            power_up(k != 0, k != 1);
        end
        step(1);
        sysrst_drive_bit_i <= 1'b0;
        step(3);
        main_power_good_i <= 1'b1;
        #1;
        chk("sys_held", sys_line, 1'b0);
        step(4);
        host_rst_gpio_sel_i <= 1'b1;
        pin_ctl_we_i <= 8'hFF;
        #1;
        chk("sys_free", sys_line, 1'b1);
        step(3);
        host_rst_gpio_sel_i <= 1'b0;
        pin_ctl_we_i <= 8'h00;
        resume_gpio_data_i <= 1'b1;
        always_on_rst_req_i <= 1'b1;
        #1;
        chk("host_gate", {host_bus_reset_n_o, sys_line}, 2'b00);
        step(3);
        always_on_rst_req_i <= 1'b0;
        #1;
        chk("resume_free", resume_line, 1'b1);
        chk("aon_pull", aon_line, 1'b0);
        for (k = 0; k < 40; k++) begin
            step(1);
            r = {$urandom, $urandom};
            if (k == 0) r = {13'h0, 8'hFF, 40'hFF_FFFF_FFFF, 3'h0};
            {debug_rst_pin_i, dbg_tdo_i, dbg_tdo_oe_i} <= r[2:0];
            pin_ctl_wdata_i <= r[42:3];
            pin_ctl_we_i <= r[50:43];
            {pin_alt_out_i, pin_alt_oe_i, pin_data_i} <= 24'($urandom);
            shadow = merge(shadow, r[50:43], r[42:3]);
            step(1);
            pin_ctl_we_i <= 8'h00;
            step(2);
            #1;
            chk("ctl", pin_ctl_o, shadow);
            chk("dbg_route", dbg_routed_o, r[2]);
            e = exp_pin(shadow[4:0], pin_alt_out_i[0], pin_alt_oe_i[0], pin_data_i[0]);
            if (r[2]) chk("dbg_oe", {dbg_tdo_pin_o, dbg_tdo_pin_oe_o}, r[1:0]);
            else chk("tdo_pin", {dbg_tdo_pin_o, dbg_tdo_pin_oe_o}, e);
            if (k == 0) chk("no_dbg_sel", {dbg_routed_o, dbg_tdo_pin_oe_o}, {1'b0, pin_alt_oe_i[0]});
            for (int j = 0; j < 8; j++) begin
                e = exp_pin(shadow[5*j +: 5], pin_alt_out_i[j], pin_alt_oe_i[j], pin_data_i[j]);
                chk("pin", {pin_out_o[j], pin_oe_o[j]}, e);
            end
        end
        end_sim;
    end
endmodule // pmx_pin_ctrl_test

// [verilog/pmx_consts.vh]
/*
 Constants for the pin power-up state and mux override block.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef PMX_CONSTS_VH
`define PMX_CONSTS_VH

// ----------------------------------------------------------------------------
// Pin function selects
// ----------------------------------------------------------------------------
`define PMX_FUNC_W 2
`define PMX_FUNC_GPIO 2'h0
`define PMX_FUNC_ALT1 2'h1
`define PMX_FUNC_ALT2 2'h2
`define PMX_FUNC_ALT3 2'h3

// ----------------------------------------------------------------------------
// Pin control word fields
// ----------------------------------------------------------------------------
`define PMX_CTL_W 5
`define PMX_CTL_FUNC_LSB 0
`define PMX_CTL_FUNC_MSB 1
`define PMX_CTL_OUT_BIT 2
`define PMX_CTL_OD_BIT 3
`define PMX_CTL_PU_BIT 4
`define PMX_CTL_RESET 5'h00
`define PMX_CTL_PU_ON 5'h10

// ----------------------------------------------------------------------------
// Power-up settle time
// ----------------------------------------------------------------------------
`define PMX_SETTLE_NS 200
`define PMX_CLK_NS 20
`define PMX_SETTLE_CYC ((`PMX_SETTLE_NS + `PMX_CLK_NS - 1) / `PMX_CLK_NS)

// ----------------------------------------------------------------------------
// Boot sequencer states
// ----------------------------------------------------------------------------
`define PMX_BOOT_IDLE 2'h0
`define PMX_BOOT_SHARED 2'h1
`define PMX_BOOT_WAIT 2'h2
`define PMX_BOOT_DONE 2'h3

`endif

// [verilog/pmx_pin_cell.v]
/*
 One multiplexed pin: holds its control word and resolves drive.
 Assumes a synchronous active-high reset and a single clock.
*/
`include "pmx_consts.vh"

module pmx_pin_cell (
    // Clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // Control word write
    input wire ctl_we_i,
    input wire [`PMX_CTL_W-1:0] ctl_wdata_i,
    // Peripheral side
    input wire alt_out_i,
    input wire alt_oe_i,
    input wire data_out_i,
    // Pin side
    output reg [`PMX_CTL_W-1:0] ctl_o,
    output reg pin_out_o,
    output reg pin_oe_o
);

    reg [`PMX_CTL_W-1:0] ctl;
    reg next_out;
    reg next_oe;

    // ------------------------------------------------------------------------
    // Control word
    // ------------------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctl <= `PMX_CTL_RESET; // R17
        end else if (ctl_we_i) begin
            ctl <= ctl_wdata_i;
        end
    end

    // ------------------------------------------------------------------------
    // Drive resolution
    // ------------------------------------------------------------------------
    always @* begin
        if (ctl[`PMX_CTL_FUNC_MSB:`PMX_CTL_FUNC_LSB] != `PMX_FUNC_GPIO) begin
            next_out = alt_out_i;
            next_oe = alt_oe_i;
        end else if (ctl[`PMX_CTL_OUT_BIT]) begin
            next_out = data_out_i;
            next_oe = ctl[`PMX_CTL_OD_BIT] ? ~data_out_i : 1'b1;
        end else begin
            next_out = 1'b0;
            next_oe = 1'b0; // R12
        end
    end

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctl_o <= `PMX_CTL_RESET;
            pin_out_o <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            ctl_o <= ctl;
            pin_out_o <= next_out;
            pin_oe_o <= next_oe;
        end
    end

endmodule // pmx_pin_cell

// [verilog/pmx_pin_ctrl.v]
/*
 Pin power-up states, glitch-protected resets, debug-port override,
 host bus reset gating and boot-time setup of flash and matrix-scan pins.
 Assumes sys_rst_i is the always-on rail power-on reset and that
 always_on_rail_good_i rises once the rail is stable.
*/
// Behaviour
// R1: Host bus reset pin used as GPIO forces internal host bus reset low.
// R2: Debug reset pin high routes debug port functions to their pins.
// R3: Debug reset pin low lets each pin control word choose the function.
// R4: No pin control word selection can route debug port functions.
// R5: System reset pin low from power-up until drive bit cleared after power good.
// R6: Resume reset pin driven low push-pull until its data bit written one.
// R7: Firmware must keep resume reset line control at GPIO default.
// R8: Boot sets shared flash pins to clock, data out, data in, select.
// R9: Private flash pins switch only if select sampled high and load succeeds.
// R10: Software should return shared flash pins to inputs before resume release.
// R11: Boot enables pull-ups on all eight matrix-scan inputs.
// R12: Open-drain and input default pins come up tri-stated.
// R13: Glitch-protected pins driven low while always-on rail rises.
// R14: Always-on reset pin becomes open-drain once rail stable.
// R15: System and resume reset pins become push-pull once rail stable.
// R16: Third two-wire data pin becomes tri-stated input once rail stable.
// R17: Pins hold power-on defaults until their control word is written.
`include "pmx_consts.vh"

module pmx_pin_ctrl #(
    parameter NUM_PINS = 8,
    parameter SCAN_PINS = 8
) (
    // Clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // Power status
    input wire always_on_rail_good_i,
    input wire main_power_good_i,
    // Debug port
    input wire debug_rst_pin_i,
    input wire dbg_tdo_i,
    input wire dbg_tdo_oe_i,
    // Host bus reset pin
    input wire host_bus_reset_n_i,
    input wire host_rst_gpio_sel_i,
    // Software controls
    input wire sysrst_drive_bit_i,
    input wire resume_gpio_data_i,
    input wire always_on_rst_req_i,
    // Boot inputs
    input wire private_flash_select_i,
    input wire flash_load_ok_i,
    input wire flash_load_done_i,
    // General pin control words
    input wire [NUM_PINS-1:0] pin_ctl_we_i,
    input wire [NUM_PINS*`PMX_CTL_W-1:0] pin_ctl_wdata_i,
    input wire [NUM_PINS-1:0] pin_alt_out_i,
    input wire [NUM_PINS-1:0] pin_alt_oe_i,
    input wire [NUM_PINS-1:0] pin_data_i,
    // Internal host bus reset
    output reg host_bus_reset_n_o,
    // Glitch-protected pins
    output reg system_rst_drive_pin_o,
    output reg system_rst_drive_pin_oe_o,
    output reg resume_rst_pin_o,
    output reg resume_rst_pin_oe_o,
    output reg always_on_rst_pin_o,
    output reg always_on_rst_pin_oe_o,
    output reg third_twowire_data_pin_o,
    output reg third_twowire_data_pin_oe_o,
    // Debug pins
    output reg dbg_routed_o,
    output reg dbg_tdo_pin_o,
    output reg dbg_tdo_pin_oe_o,
    // Flash and scan setup
    output reg [`PMX_FUNC_W-1:0] shared_flash_func_o,
    output reg [`PMX_FUNC_W-1:0] private_flash_func_o,
    output reg [SCAN_PINS-1:0] matrix_scan_input_pu_o,
    output reg boot_done_o,
    // General pins
    output reg [NUM_PINS*`PMX_CTL_W-1:0] pin_ctl_o,
    output reg [NUM_PINS-1:0] pin_out_o,
    output reg [NUM_PINS-1:0] pin_oe_o
);

    localparam [1:0] BOOT_IDLE = `PMX_BOOT_IDLE;
    localparam [1:0] BOOT_SHARED = `PMX_BOOT_SHARED;
    localparam [1:0] BOOT_WAIT = `PMX_BOOT_WAIT;
    localparam [1:0] BOOT_DONE = `PMX_BOOT_DONE;
    localparam integer SETTLE_FULL = `PMX_SETTLE_CYC;
    localparam [7:0] SETTLE_CYC = SETTLE_FULL[7:0];

    reg [7:0] settle_cnt;
    reg rail_stable;
    reg sysrst_hold;
    reg resume_high;
    reg [1:0] boot_state;
    reg [1:0] next_boot_state;
    reg pvt_sampled;
    wire [NUM_PINS*`PMX_CTL_W-1:0] cell_ctl;
    wire [NUM_PINS-1:0] cell_out;
    wire [NUM_PINS-1:0] cell_oe;

    // ------------------------------------------------------------------------
    // Rail stable detect
    // ------------------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            settle_cnt <= 8'h00;
            rail_stable <= 1'b0;
        end else if (!always_on_rail_good_i) begin
            settle_cnt <= 8'h00;
            rail_stable <= 1'b0;
        end else if (settle_cnt < SETTLE_CYC) begin
            settle_cnt <= settle_cnt + 8'h01;
        end else begin
            rail_stable <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // System reset hold and resume line latch
    // ------------------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sysrst_hold <= 1'b1;
            resume_high <= 1'b0;
        end else begin
            if (main_power_good_i && !sysrst_drive_bit_i) begin
                sysrst_hold <= 1'b0; // R5
            end else if (!main_power_good_i) begin
                sysrst_hold <= 1'b1; // R5
            end
            if (rail_stable) begin
                resume_high <= resume_gpio_data_i; // R6
            end
        end
    end

    // ------------------------------------------------------------------------
    // Boot sequencer
    // ------------------------------------------------------------------------
    always @* begin
        case (boot_state)
            BOOT_IDLE: next_boot_state = rail_stable ? BOOT_SHARED : BOOT_IDLE;
            BOOT_SHARED: next_boot_state = BOOT_WAIT;
            BOOT_WAIT: next_boot_state = flash_load_done_i ? BOOT_DONE : BOOT_WAIT;
            BOOT_DONE: next_boot_state = BOOT_DONE;
            default: next_boot_state = BOOT_IDLE;
        endcase
    end

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            boot_state <= BOOT_IDLE;
            pvt_sampled <= 1'b0;
            shared_flash_func_o <= `PMX_FUNC_GPIO;
            private_flash_func_o <= `PMX_FUNC_GPIO;
            matrix_scan_input_pu_o <= {SCAN_PINS{1'b0}};
            boot_done_o <= 1'b0;
        end else begin
            boot_state <= next_boot_state;
            if (boot_state == BOOT_SHARED) begin
                shared_flash_func_o <= `PMX_FUNC_ALT1; // R8
                matrix_scan_input_pu_o <= {SCAN_PINS{1'b1}}; // R11
                pvt_sampled <= private_flash_select_i;
            end
            if (boot_state == BOOT_WAIT && flash_load_done_i) begin
                boot_done_o <= 1'b1;
                if (pvt_sampled && flash_load_ok_i) begin
                    private_flash_func_o <= `PMX_FUNC_ALT1; // R9
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Glitch-protected pins and host reset gate
    // ------------------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            host_bus_reset_n_o <= 1'b0;
            system_rst_drive_pin_o <= 1'b0;
            system_rst_drive_pin_oe_o <= 1'b1;
            resume_rst_pin_o <= 1'b0;
            resume_rst_pin_oe_o <= 1'b1;
            always_on_rst_pin_o <= 1'b0;
            always_on_rst_pin_oe_o <= 1'b1;
            third_twowire_data_pin_o <= 1'b0;
            third_twowire_data_pin_oe_o <= 1'b1;
        end else begin
            host_bus_reset_n_o <= host_rst_gpio_sel_i ? 1'b0 : host_bus_reset_n_i; // R1
            if (!rail_stable) begin
                system_rst_drive_pin_o <= 1'b0; // R13
                system_rst_drive_pin_oe_o <= 1'b1;
                resume_rst_pin_o <= 1'b0;
                resume_rst_pin_oe_o <= 1'b1;
                always_on_rst_pin_o <= 1'b0;
                always_on_rst_pin_oe_o <= 1'b1;
                third_twowire_data_pin_o <= 1'b0;
                third_twowire_data_pin_oe_o <= 1'b1;
            end else begin
                system_rst_drive_pin_o <= ~sysrst_hold & main_power_good_i & ~sysrst_drive_bit_i & host_bus_reset_n_o; // R5 R15
                system_rst_drive_pin_oe_o <= 1'b1;
                resume_rst_pin_o <= resume_high & resume_gpio_data_i; // R6 R15
                resume_rst_pin_oe_o <= 1'b1;
                always_on_rst_pin_o <= 1'b0;
                always_on_rst_pin_oe_o <= always_on_rst_req_i; // R14
                third_twowire_data_pin_o <= 1'b0;
                third_twowire_data_pin_oe_o <= 1'b0; // R16
            end
        end
    end

    // ------------------------------------------------------------------------
    // Debug port override
    // ------------------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            dbg_routed_o <= 1'b0;
            dbg_tdo_pin_o <= 1'b0;
            dbg_tdo_pin_oe_o <= 1'b0;
        end else begin
            dbg_routed_o <= debug_rst_pin_i; // R2
            dbg_tdo_pin_o <= debug_rst_pin_i ? dbg_tdo_i : cell_out[0]; // R2 R3
            dbg_tdo_pin_oe_o <= debug_rst_pin_i ? dbg_tdo_oe_i : cell_oe[0]; // R3
        end
    end

    // ------------------------------------------------------------------------
    // General pins; control words carry no debug selection
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
            pmx_pin_cell u_cell (
                .mclk_i(mclk_i),
                .sys_rst_i(sys_rst_i),
                .ctl_we_i(pin_ctl_we_i[gi]),
                .ctl_wdata_i(pin_ctl_wdata_i[gi*`PMX_CTL_W +: `PMX_CTL_W]),
                .alt_out_i(pin_alt_out_i[gi]),
                .alt_oe_i(pin_alt_oe_i[gi]),
                .data_out_i(pin_data_i[gi]),
                .ctl_o(cell_ctl[gi*`PMX_CTL_W +: `PMX_CTL_W]),
                .pin_out_o(cell_out[gi]),
                .pin_oe_o(cell_oe[gi])
            ); // R4 R17
        end
    endgenerate

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pin_ctl_o <= {NUM_PINS*`PMX_CTL_W{1'b0}};
            pin_out_o <= {NUM_PINS{1'b0}};
            pin_oe_o <= {NUM_PINS{1'b0}};
        end else begin
            pin_ctl_o <= cell_ctl;
            pin_out_o <= cell_out;
            pin_oe_o <= cell_oe; // R12
        end
    end

endmodule // pmx_pin_ctrl
